// ### rtl/frame_sync_pin_routing.sv
// frame-sync input routing, strap capture and 8k/2k sync output generation
`default_nettype none
module frame_sync_pin_routing
	import frame_sync_pkg::*;
#(
	parameter int EIGHT_KHZ_SYNC_OUT_PERIOD = EIGHT_KHZ_SYNC_OUT_PERIOD_CYC
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic frame_sync_in_a,
	input wire logic frame_sync_in_b,
	input wire logic frame_sync_in_c,
	input wire logic se_out_freq_sel_bit1,
	input wire logic se_out_freq_sel_bit2,
	input wire logic [2:0] diff_out_freq_sel,
	input wire logic [3:0] sync_source_select,
	input wire logic [3:0] sync_source_select_alt,
	input wire logic [1:0] sync_pairing_select,
	input wire logic [3:0] selected_ref,
	input wire logic [1:0] diff_out_mode_select,
	input wire logic eight_khz_invert,
	input wire logic eight_khz_pulse_mode,
	input wire logic two_khz_invert,
	input wire logic two_khz_pulse_mode,
	input wire logic ref_nine_freq_wr,
	input wire logic [19:0] ref_nine_freq_khz_in,
	output ext_sync_t sync_a,
	output ext_sync_t sync_b,
	output ext_sync_t sync_c,
	output logic [2:0] se_out_freq_sel,
	output logic [2:0] diff_out_freq_sel_latched,
	output logic se_default_19m44,
	output logic diff_default_38m88,
	output logic straps_valid,
	output diff_mode_t diff_out_mode,
	output logic [19:0] ref_nine_freq_khz,
	output logic eight_khz_sync_out,
	output logic two_khz_multiframe_out
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [PIN_N-1:0] pins_raw;
	logic [PIN_N-1:0] meta_q;
	logic [PIN_N-1:0] sync_q;
	logic [PIN_N-1:0] prev_q;
	logic [PIN_N-1:0] rise;
	assign pins_raw = {diff_out_freq_sel, se_out_freq_sel_bit2, se_out_freq_sel_bit1,
		frame_sync_in_c, frame_sync_in_b, frame_sync_in_a};
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++)
		begin : g_pin
			always_ff @(posedge core_clk or posedge rst)
			begin
				if (rst)
					meta_q[gi] <= 1'b0;
				else
					meta_q[gi] <= pins_raw[gi];
			end
			always_ff @(posedge core_clk or posedge rst)
			begin
				if (rst)
					sync_q[gi] <= 1'b0;
				else
					sync_q[gi] <= meta_q[gi];
			end
			always_ff @(posedge core_clk or posedge rst)
			begin
				if (rst)
					prev_q[gi] <= 1'b0;
				else
					prev_q[gi] <= sync_q[gi];
			end
			assign rise[gi] = sync_q[gi] & ~prev_q[gi];
		end
	endgenerate
	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------
	strap_state_t strap_q;
	logic [1:0] settle_q;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			strap_q <= STRAP_SETTLE;
			settle_q <= 2'h0;
		end
		else
		begin
			case (strap_q)
				STRAP_SETTLE:
				begin
					if (settle_q == 2'(STRAP_SETTLE_CYC))
						strap_q <= STRAP_HELD;
					else
						settle_q <= settle_q + 2'h1;
				end
				STRAP_HELD: strap_q <= STRAP_HELD;
				default: strap_q <= STRAP_SETTLE;
			endcase
		end
	end
	logic capture;
	assign capture = (strap_q == STRAP_SETTLE) && (settle_q == 2'(STRAP_SETTLE_CYC));
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			se_out_freq_sel <= SE_OPEN_CODE;
		else if (capture)
			se_out_freq_sel <= {sync_q[PIN_SE2], sync_q[PIN_SE1], sync_q[PIN_C]};
	end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			diff_out_freq_sel_latched <= DIFF_OPEN_CODE;
		else if (capture)
			diff_out_freq_sel_latched <= {sync_q[PIN_DIFF2], sync_q[PIN_DIFF1], sync_q[PIN_DIFF0]};
	end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			straps_valid <= 1'b0;
		else if (capture)
			straps_valid <= 1'b1;
	end
	// ------------------------------------------------------------
	// default frequency flags
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			se_default_19m44 <= 1'b1;
		else
			se_default_19m44 <= (se_out_freq_sel == SE_OPEN_CODE);
	end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			diff_default_38m88 <= 1'b1;
		else
			diff_default_38m88 <= (diff_out_freq_sel_latched == DIFF_OPEN_CODE);
	end
	// ------------------------------------------------------------
	// sync input routing
	// ------------------------------------------------------------
	function automatic logic [3:0] pick_ref(input logic [1:0] mode, input logic [3:0] sel,
		input logic [3:0] lo, input logic [3:0] hi);
		logic [3:0] r;
		r = lo;
		case (mode)
			PAIR_LOW: r = lo;
			PAIR_HIGH: r = hi;
			default: r = (sel == hi) ? hi : lo;
		endcase
		return r;
	endfunction
	logic paired;
	logic paired_alt;
	assign paired = (sync_source_select[3:2] == SRC_PAIRED_TOP);
	assign paired_alt = (sync_source_select_alt[3:2] == SRC_PAIRED_TOP);
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			sync_a <= '0;
		else
		begin
			sync_a.valid <= 1'b1;
			sync_a.level <= sync_q[PIN_A];
			sync_a.rise <= rise[PIN_A];
			if (paired)
				sync_a.ref_index <= pick_ref(sync_pairing_select, selected_ref, REF_THREE, REF_FIVE);
			else
				sync_a.ref_index <= sync_source_select;
		end
	end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			sync_b <= '0;
		else
		begin
			sync_b.valid <= paired;
			sync_b.level <= paired & sync_q[PIN_B];
			sync_b.rise <= paired & rise[PIN_B];
			if (paired)
				sync_b.ref_index <= pick_ref(sync_pairing_select, selected_ref, REF_FOUR, REF_SIX);
			else
				sync_b.ref_index <= REF_NONE;
		end
	end
	// ------------------------------------------------------------
	// third sync routing
	// ------------------------------------------------------------
	logic c_use;
	assign c_use = straps_valid & paired_alt;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			sync_c <= '0;
		else
		begin
			sync_c.valid <= c_use;
			sync_c.ref_index <= c_use ? REF_NINE : REF_NONE;
			sync_c.level <= c_use & sync_q[PIN_C];
			sync_c.rise <= c_use & rise[PIN_C];
		end
	end
	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			diff_out_mode <= DIFF_MODE_0;
		else
			diff_out_mode <= diff_mode_t'(diff_out_mode_select);
	end
	// ------------------------------------------------------------
	// reference nine frequency
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			ref_nine_freq_khz <= REF_NINE_DEFAULT_KHZ;
		else if (ref_nine_freq_wr)
			ref_nine_freq_khz <= ref_nine_freq_khz_in;
	end
	// ------------------------------------------------------------
	// 8kHz and 2kHz sync generation
	// ------------------------------------------------------------
	logic [PERIOD_W-1:0] phase_q;
	logic [MF_W-1:0] frame_q;
	logic period_end;
	assign period_end = (phase_q == PERIOD_W'(EIGHT_KHZ_SYNC_OUT_PERIOD - 1));
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			phase_q <= '0;
		else if (period_end)
			phase_q <= '0;
		else
			phase_q <= phase_q + PERIOD_W'(1);
	end
	// ------------------------------------------------------------
	// multiframe counter
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			frame_q <= '0;
		else if (period_end)
			frame_q <= frame_q + MF_W'(1);
	end
	// ------------------------------------------------------------
	// pulse and clock decode
	// ------------------------------------------------------------
	logic eight_clk;
	logic eight_pulse;
	logic two_clk;
	logic two_pulse;
	assign eight_clk = (phase_q < PERIOD_W'(EIGHT_KHZ_SYNC_OUT_PERIOD / 2));
	assign eight_pulse = (phase_q < PERIOD_W'(PULSE_WIDTH_CYC));
	assign two_clk = (frame_q < MF_W'(MULTIFRAME_RATIO / 2));
	assign two_pulse = (frame_q == '0) && eight_pulse;
	// ------------------------------------------------------------
	// output drivers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			eight_khz_sync_out <= 1'b0;
		else
			eight_khz_sync_out <= (eight_khz_pulse_mode ? eight_pulse : eight_clk) ^ eight_khz_invert;
	end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			two_khz_multiframe_out <= 1'b0;
		else
			two_khz_multiframe_out <= (two_khz_pulse_mode ? two_pulse : two_clk) ^ two_khz_invert;
	end
endmodule
`default_nettype wire

// ### rtl/frame_sync_pkg.sv
// constants and types for frame-sync pin routing
`default_nettype none
package frame_sync_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int EIGHT_KHZ_HZ = 8000;
	localparam int TWO_KHZ_HZ = 2000;
	localparam int EIGHT_KHZ_SYNC_OUT_PERIOD_CYC = CLK_HZ / EIGHT_KHZ_HZ;
	localparam int MULTIFRAME_RATIO = EIGHT_KHZ_HZ / TWO_KHZ_HZ;
	localparam int PULSE_WIDTH_NS = 20;
	localparam int PULSE_WIDTH_CYC_RAW = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_WIDTH_CYC = (PULSE_WIDTH_CYC_RAW < 1) ? 1 : PULSE_WIDTH_CYC_RAW;
	localparam int PERIOD_W = 16;
	localparam int MF_W = 2;
	// ------------------------------------------------------------
	// source fields and reference indices
	// ------------------------------------------------------------
	localparam logic [1:0] SRC_PAIRED_TOP = 2'h3;
	localparam logic [3:0] REF_NONE = 4'h0;
	localparam logic [3:0] REF_THREE = 4'h3;
	localparam logic [3:0] REF_FOUR = 4'h4;
	localparam logic [3:0] REF_FIVE = 4'h5;
	localparam logic [3:0] REF_SIX = 4'h6;
	localparam logic [3:0] REF_NINE = 4'h9;
	localparam logic [1:0] PAIR_FOLLOW = 2'h0;
	localparam logic [1:0] PAIR_LOW = 2'h1;
	localparam logic [1:0] PAIR_HIGH = 2'h2;
	// ------------------------------------------------------------
	// strap defaults (pin pulls when left open)
	// ------------------------------------------------------------
	localparam logic [2:0] SE_OPEN_CODE = 3'h3;
	localparam logic [2:0] DIFF_OPEN_CODE = 3'h4;
	localparam int STRAP_SETTLE_CYC = 2;
	localparam logic [19:0] REF_NINE_DEFAULT_KHZ = 20'h04BF0;
	// ------------------------------------------------------------
	// pin synchroniser slots
	// ------------------------------------------------------------
	localparam int PIN_N = 8;
	localparam int PIN_A = 0;
	localparam int PIN_B = 1;
	localparam int PIN_C = 2;
	localparam int PIN_SE1 = 3;
	localparam int PIN_SE2 = 4;
	localparam int PIN_DIFF0 = 5;
	localparam int PIN_DIFF1 = 6;
	localparam int PIN_DIFF2 = 7;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {DIFF_MODE_0, DIFF_MODE_1, DIFF_MODE_2, DIFF_MODE_3} diff_mode_t;
	typedef enum logic {STRAP_SETTLE, STRAP_HELD} strap_state_t;
	typedef struct packed {
		logic valid;
		logic [3:0] ref_index;
		logic level;
		logic rise;
	} ext_sync_t;
endpackage
`default_nettype wire

// ### bench/timing_card_model.sv
// far-side timing card model driving one frame-sync pin
`default_nettype none
module timing_card_model #(
	parameter int PERIOD = 8
)
(
	input wire logic core_clk,
	output logic fs = 1'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	always @(posedge core_clk)
	begin
		cnt <= (cnt + 1) % PERIOD;
		fs <= cnt < PERIOD / 2;
	end
endmodule
`default_nettype wire

// ### bench/frame_sync_pin_routing_assertions.sv
// assertion checker for frame-sync pin routing
`default_nettype none
module frame_sync_pin_routing_assertions
	import frame_sync_pkg::*;
#(
	parameter int EIGHT_KHZ_SYNC_OUT_PERIOD = EIGHT_KHZ_SYNC_OUT_PERIOD_CYC
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic frame_sync_in_a,
	input wire logic frame_sync_in_b,
	input wire logic frame_sync_in_c,
	input wire logic se_out_freq_sel_bit1,
	input wire logic se_out_freq_sel_bit2,
	input wire logic [2:0] diff_out_freq_sel,
	input wire logic [3:0] sync_source_select,
	input wire logic [3:0] sync_source_select_alt,
	input wire logic [1:0] sync_pairing_select,
	input wire logic [3:0] selected_ref,
	input wire logic [1:0] diff_out_mode_select,
	input wire logic eight_khz_invert,
	input wire logic eight_khz_pulse_mode,
	input wire logic two_khz_invert,
	input wire logic two_khz_pulse_mode,
	input wire logic ref_nine_freq_wr,
	input wire logic [19:0] ref_nine_freq_khz_in,
	input wire ext_sync_t sync_a,
	input wire ext_sync_t sync_b,
	input wire ext_sync_t sync_c,
	input wire logic [2:0] se_out_freq_sel,
	input wire logic [2:0] diff_out_freq_sel_latched,
	input wire logic se_default_19m44,
	input wire logic diff_default_38m88,
	input wire logic straps_valid,
	input wire diff_mode_t diff_out_mode,
	input wire logic [19:0] ref_nine_freq_khz,
	input wire logic eight_khz_sync_out,
	input wire logic two_khz_multiframe_out
);
	logic [2:0] up_q;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			up_q <= 3'h0;
		else if (up_q != 3'h7)
			up_q <= up_q + 3'h1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	settle_a: assert property (up_q == 3'h2 |-> !straps_valid ##1 straps_valid) else $error("capture late");
	se_capture_a: assert property ($rose(straps_valid) |-> se_out_freq_sel[2:1] ==
		{$past(se_out_freq_sel_bit2, 3), $past(se_out_freq_sel_bit1, 3)}) else $error("se straps wrong");
	strap_hold_a: assert property (straps_valid && $past(straps_valid) |-> $stable(se_out_freq_sel))
		else $error("strap code moved");
	open_flag_a: assert property (straps_valid && $past(straps_valid) |->
		se_default_19m44 == (se_out_freq_sel == SE_OPEN_CODE)) else $error("open flag wrong");
	b_ignore_a: assert property ((sync_source_select[3:2] != 2'h3) [*3] |-> !sync_b.valid)
		else $error("second sync used");
	pair_low_a: assert property ((sync_source_select[3:2] == 2'h3 && sync_pairing_select == PAIR_LOW) [*3] |->
		sync_a.ref_index == REF_THREE && sync_b.ref_index == REF_FOUR) else $error("low pairing wrong");
	c_gate_a: assert property ((sync_source_select_alt[3:2] != 2'h3) [*3] |-> !sync_c.valid)
		else $error("third sync used");
	level_a: assert property (up_q == 3'h7 && sync_a.valid |-> sync_a.level == $past(frame_sync_in_a, 3))
		else $error("sync level path");
	rise_a: assert property (up_q == 3'h7 && sync_a.valid |-> sync_a.rise ==
		($past(frame_sync_in_a, 3) && !$past(frame_sync_in_a, 4))) else $error("sync rise path");
	b_level_a: assert property (up_q == 3'h7 && sync_b.valid |-> sync_b.level == $past(frame_sync_in_b, 3))
		else $error("second sync level");
	c_level_a: assert property (up_q == 3'h7 && sync_c.valid |-> sync_c.level == $past(frame_sync_in_c, 3))
		else $error("third sync level");
	mode_a: assert property (up_q > 3'h1 |-> diff_out_mode == $past(diff_out_mode_select))
		else $error("mode not followed");
	cover property ($rose(straps_valid));
	cover property (sync_b.valid && sync_b.ref_index == REF_SIX);
	cover property (sync_c.valid);
endmodule
bind frame_sync_pin_routing frame_sync_pin_routing_assertions #(.EIGHT_KHZ_SYNC_OUT_PERIOD(EIGHT_KHZ_SYNC_OUT_PERIOD)) chk_i (.*);
`default_nettype wire

// ### bench/test_frame_sync_pin_routing.sv
// self-checking bench for frame-sync pin routing
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s %0h %0h", n, e, g); end end
module test_frame_sync_pin_routing
	import frame_sync_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int P = 16;
	logic core_clk = 1'h0, rst = 1'h1, strap_c, use_strap = 1'h1, se_out_freq_sel_bit1, se_out_freq_sel_bit2;
	logic eight_khz_invert = 1'h0, eight_khz_pulse_mode = 1'h0, two_khz_invert = 1'h0, two_khz_pulse_mode = 1'h0;
	logic ref_nine_freq_wr = 1'h0, straps_valid, se_default_19m44, diff_default_38m88, eight_khz_sync_out;
	logic two_khz_multiframe_out, frame_sync_in_a, frame_sync_in_b, fs_c;
	wire logic frame_sync_in_c = use_strap ? strap_c : fs_c;
	logic [1:0] sync_pairing_select = 2'h1, diff_out_mode_select = 2'h0;
	logic [2:0] diff_out_freq_sel, se_out_freq_sel, diff_out_freq_sel_latched;
	logic [3:0] sync_source_select = 4'h0, sync_source_select_alt = 4'h0, selected_ref = 4'h3;
	logic [7:0] r;
	logic [19:0] ref_nine_freq_khz_in = 20'h0, ref_nine_freq_khz;
	ext_sync_t sync_a, sync_b, sync_c;
	diff_mode_t diff_out_mode;
	int bad_count = 0, checked = 0, cyc = 0;
	logic [31:0] hi8, hi2;
	frame_sync_pin_routing #(.EIGHT_KHZ_SYNC_OUT_PERIOD(P)) frame_sync_pin_routing_i (.*);
	timing_card_model #(.PERIOD(64)) card_a (.core_clk, .fs(frame_sync_in_a));
	timing_card_model #(.PERIOD(32)) card_b (.core_clk, .fs(frame_sync_in_b));
	timing_card_model #(.PERIOD(16)) card_c (.core_clk, .fs(fs_c));
	always #10 core_clk = ~core_clk;
	function automatic logic [3:0] exp_ref(input logic [3:0] src, input logic [1:0] pr, input logic [3:0] sel,
		input logic b);
		if (src[3:2] != 2'h3)
			return b ? REF_NONE : src;
		if (pr == PAIR_LOW || (pr != PAIR_HIGH && sel != (b ? REF_SIX : REF_FIVE)))
			return b ? REF_FOUR : REF_THREE;
		return b ? REF_SIX : REF_FIVE;
	endfunction
	function automatic int exp_hi(input logic inv, input logic pul, input int npul);
		int n;
		n = pul ? npul : 2 * P;
		return inv ? 4 * P - n : n;
	endfunction
	task automatic final_report;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic do_reset(input logic [2:0] se, input logic [2:0] df);
		rst = 1'h1;
		use_strap = 1'h1;
		{se_out_freq_sel_bit2, se_out_freq_sel_bit1, strap_c} = se;
		diff_out_freq_sel = df;
		repeat (5) @(posedge core_clk);
		#2 `CHK("in reset", 1'h0, straps_valid)
		rst = 1'h0;
		repeat (5) @(posedge core_clk);
		#2 `CHK("se code", se, se_out_freq_sel)
		`CHK("diff code", df, diff_out_freq_sel_latched)
		`CHK("se flag", se === SE_OPEN_CODE, se_default_19m44)
		`CHK("diff flag", df === DIFF_OPEN_CODE, diff_default_38m88)
		`CHK("nine freq", 20'h04BF0, ref_nine_freq_khz)
		{se_out_freq_sel_bit2, se_out_freq_sel_bit1, strap_c} = ~se;
		diff_out_freq_sel = ~df;
		use_strap = 1'h0;
		repeat (3) @(posedge core_clk);
		#2 `CHK("se held", se, se_out_freq_sel)
		`CHK("diff held", df, diff_out_freq_sel_latched)
	endtask
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			bad_count++;
			final_report();
		end
	end
	initial
	begin
		void'($urandom(90045));
		do_reset(SE_OPEN_CODE, DIFF_OPEN_CODE);
		for (int k = 0; k < 4; k++)
		begin
			{eight_khz_invert, eight_khz_pulse_mode, two_khz_invert, two_khz_pulse_mode} = {2'(k), 2'(3 - k)};
			repeat (2) @(posedge core_clk);
			hi8 = 0;
			hi2 = 0;
			repeat (4 * P)
			begin
				@(posedge core_clk);
				#2 hi8 += eight_khz_sync_out;
				hi2 += two_khz_multiframe_out;
			end
			`CHK("8k highs", exp_hi(eight_khz_invert, eight_khz_pulse_mode, 4 * PULSE_WIDTH_CYC), hi8)
			`CHK("2k highs", exp_hi(two_khz_invert, two_khz_pulse_mode, PULSE_WIDTH_CYC), hi2)
			diff_out_mode_select = 2'(k);
		end
		@(posedge core_clk);
		#2 `CHK("mode", diff_mode_t'(2'h3), diff_out_mode)
		ref_nine_freq_khz_in = 20'($urandom);
		ref_nine_freq_wr = 1'h1;
		@(posedge core_clk);
		#2 ref_nine_freq_wr = 1'h0;
		@(posedge core_clk);
		#2 `CHK("nine write", ref_nine_freq_khz_in, ref_nine_freq_khz)
		repeat (24)
		begin
			r = 8'($urandom);
			{sync_source_select, sync_source_select_alt} = r;
			sync_pairing_select = 2'($urandom);
			selected_ref = REF_THREE + 4'($urandom % 4);
			repeat (5) @(posedge core_clk);
			#2 `CHK("a ref", exp_ref(r[7:4], sync_pairing_select, selected_ref, 1'h0), sync_a.ref_index)
			`CHK("b ref", exp_ref(r[7:4], sync_pairing_select, selected_ref, 1'h1), sync_b.ref_index)
			`CHK("c valid", r[3:2] == 2'h3, sync_c.valid)
		end
		do_reset(3'($urandom), 3'($urandom));
		final_report();
	end
endmodule
`default_nettype wire
